// [branch_bitset_decode_cfg.svh]
/*
 constants for the relative jump, bit-set and bit-test-skip decoder:
 opcode patterns, field positions, phase codes and address limits.
 assumes a core where four sys_clk edges make one instruction cycle.
*/
//
// Functional notes
// RQ1: relative_jump is 11010 plus signed 11-bit offset
// RQ2: jump target is incremented pc plus twice offset
// RQ3: jump takes two cycles, pc written in Q4
// RQ4: file_bit_set forces chosen bit one via rmw
// RQ5: selector zero access bank, one uses bank_select_register
// RQ6: extended set, selector zero, f<=95: indexed addressing
// RQ7: test_skip_if_one skips when bit reads one
// RQ8: skip discards fetched word, runs nop instead
// RQ9: test_skip_if_zero skips on zero; else one cycle
`ifndef BRANCH_BITSET_DECODE_CFG_SVH
`define BRANCH_BITSET_DECODE_CFG_SVH

// ----------------------------------------------------------------
// opcode patterns
// ----------------------------------------------------------------
`define OPC_JUMP 5'h1a
`define OPC_BIT_SET 4'h8
`define OPC_SKIP_ZERO 4'hb
`define OPC_SKIP_ONE 4'ha

// ----------------------------------------------------------------
// field positions and widths
// ----------------------------------------------------------------
`define OFFSET_W 11
`define PC_W 21
`define ADDR_W 12
`define BSR_W 4
`define BIT_MSB 11
`define BIT_LSB 9
`define SEL_BIT 8

// ----------------------------------------------------------------
// phase codes within one instruction cycle
// ----------------------------------------------------------------
`define PH_Q1 2'h0
`define PH_Q2 2'h1
`define PH_Q3 2'h2
`define PH_Q4 2'h3

// ----------------------------------------------------------------
// addressing limits
// ----------------------------------------------------------------
`define INDEX_MAX 8'h5f
`define ACCESS_SPLIT 8'h60
`define ACCESS_HI_BANK 4'hf
`define ACCESS_LO_BANK 4'h0

`endif

// [branch_bitset_decode_pkg.sv]
/*
 types shared by the decoder files.
 assumes branch_bitset_decode_cfg.svh supplies the widths.
*/
`default_nettype none
`include "branch_bitset_decode_cfg.svh"
package branch_bitset_decode_pkg;
  // execute state of one instruction cycle
  typedef enum logic [0:0] {
    ST_EXEC = 1'b0,
    ST_NOP = 1'b1
  } exec_state_t;
  typedef logic [`ADDR_W-1:0] data_addr_t;
  typedef logic [`PC_W-1:0] prog_addr_t;
endpackage : branch_bitset_decode_pkg
`default_nettype wire

// [operand_address.sv]
/*
 resolves the data address of a bit-oriented operand.
 assumes index_base carries the base pointer used by indexed literal
 offset mode, already settled when the word is captured.
*/
`default_nettype none
`include "branch_bitset_decode_cfg.svh"
module operand_address
  import branch_bitset_decode_pkg::*;
(
  // operand fields
  input wire logic [7:0] file_addr,
  input wire logic bank_sel,
  // core state
  input wire logic [`BSR_W-1:0] bank_select_register,
  input wire logic ext_set_en,
  input wire logic [`ADDR_W-1:0] index_base,
  // result
  output data_addr_t data_addr
);
  // ----------------------------------------------------------------
  // address selection
  // ----------------------------------------------------------------
  // purely combinational so the address is ready inside Q1
  always_comb begin
    if (bank_sel) begin
      data_addr = {bank_select_register, file_addr}; // RQ5
    end else if (ext_set_en && file_addr <= `INDEX_MAX) begin
      data_addr = index_base + {4'h0, file_addr}; // RQ6
    end else if (file_addr < `ACCESS_SPLIT) begin
      data_addr = {`ACCESS_LO_BANK, file_addr}; // RQ5
    end else begin
      // access addresses from 8'h60 up map onto the special function area
      data_addr = {`ACCESS_HI_BANK, file_addr}; // RQ5
    end
  end
endmodule : operand_address
`default_nettype wire

// [branch_bitset_decode.sv]
/*
 decode and execute of relative_jump, file_bit_set and the two
 test-and-skip instructions, one instruction cycle per four clocks.
 assumes the fetch unit presents the word and the incremented pc
 during Q1, and data memory answers a Q2 read during Q3.
*/
`default_nettype none
`include "branch_bitset_decode_cfg.svh"
module branch_bitset_decode
  import branch_bitset_decode_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // fetched instruction
  input wire logic [15:0] instr_word,
  input wire logic instr_valid,
  input wire prog_addr_t pc_inc,
  // core state
  input wire logic [`BSR_W-1:0] bank_select_register,
  input wire logic ext_set_en,
  input wire logic [`ADDR_W-1:0] index_base,
  // data memory
  output data_addr_t mem_addr,
  output logic mem_rd_en,
  input wire logic [7:0] mem_rdata,
  output logic mem_wr_en,
  output logic [7:0] mem_wdata,
  // program counter and pipeline
  output logic pc_load,
  output prog_addr_t pc_next,
  output logic flush,
  output logic [1:0] phase,
  output logic nop_cycle
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [1:0] phase_r; // current quarter of the cycle
  exec_state_t state_r; // exec or forced nop
  logic [15:0] instr_r; // word held for the whole cycle
  logic instr_v_r; // held word is a real instruction
  prog_addr_t pc_r; // incremented pc of the held word
  data_addr_t addr_nxt; // resolved operand address
  data_addr_t mem_addr_r;
  logic rd_en_r;
  logic wr_en_r;
  logic [7:0] wdata_r;
  logic [7:0] rdata_r; // operand as read in Q3
  logic pc_load_r;
  prog_addr_t pc_next_r;
  logic flush_r;
  // decode of the incoming word
  logic dec_jump, dec_set, dec_skz, dec_sko;
  // decode of the held word
  logic is_jump, is_set, is_skz, is_sko;
  logic [7:0] bit_mask; // one-hot select of bit b
  logic bit_val; // tested bit of the memory answer
  logic skip_now; // test result says skip

  assign dec_jump = instr_word[15:11] == `OPC_JUMP; // RQ1
  assign dec_set = instr_word[15:12] == `OPC_BIT_SET; // RQ4
  assign dec_skz = instr_word[15:12] == `OPC_SKIP_ZERO;
  assign dec_sko = instr_word[15:12] == `OPC_SKIP_ONE;
  assign is_jump = instr_v_r && instr_r[15:11] == `OPC_JUMP; // RQ1
  assign is_set = instr_v_r && instr_r[15:12] == `OPC_BIT_SET;
  assign is_skz = instr_v_r && instr_r[15:12] == `OPC_SKIP_ZERO;
  assign is_sko = instr_v_r && instr_r[15:12] == `OPC_SKIP_ONE;
  assign bit_mask = 8'h01 << instr_r[`BIT_MSB:`BIT_LSB];
  assign bit_val = |(mem_rdata & bit_mask);
  assign skip_now = (is_sko && bit_val) || (is_skz && !bit_val); // RQ7 RQ9

  // operand address resolved straight from the fetched word
  operand_address u_addr (
    .file_addr(instr_word[7:0]),
    .bank_sel(instr_word[`SEL_BIT]),
    .bank_select_register(bank_select_register),
    .ext_set_en(ext_set_en),
    .index_base(index_base),
    .data_addr(addr_nxt)
  );

  // ----------------------------------------------------------------
  // phase counter
  // ----------------------------------------------------------------
  // free running; the core derives its q clocks from the same count
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      phase_r <= `PH_Q1;
    end else begin
      phase_r <= phase_r + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // instruction capture at the end of Q1
  // ----------------------------------------------------------------
  // a word arriving in a nop cycle is the discarded one: dropped here
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      instr_r <= 16'h0000;
      instr_v_r <= 1'b0;
      pc_r <= '0;
    end else if (phase_r == `PH_Q1) begin
      instr_r <= instr_word;
      instr_v_r <= instr_valid && state_r == ST_EXEC; // RQ3 RQ8
      pc_r <= pc_inc;
    end
  end

  // ----------------------------------------------------------------
  // operand read, driven through Q2
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rd_en_r <= 1'b0;
      mem_addr_r <= '0;
    end else if (phase_r == `PH_Q1) begin
      // jump reads no register, only its literal
      rd_en_r <= instr_valid && state_r == ST_EXEC &&
                 (dec_set || dec_skz || dec_sko); // RQ4 RQ7 RQ9
      mem_addr_r <= addr_nxt; // RQ5 RQ6
    end else begin
      rd_en_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // process in Q3, results shown through Q4
  // ----------------------------------------------------------------
  // registered so every data output is clean for the whole of Q4
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wr_en_r <= 1'b0;
      wdata_r <= 8'h00;
      rdata_r <= 8'h00;
      pc_load_r <= 1'b0;
      pc_next_r <= '0;
      flush_r <= 1'b0;
    end else if (phase_r == `PH_Q3) begin
      rdata_r <= mem_rdata;
      wr_en_r <= is_set; // RQ4
      wdata_r <= mem_rdata | bit_mask; // RQ4
      pc_load_r <= is_jump; // RQ3
      // pc plus twice the sign-extended offset; no flags touched
      pc_next_r <= pc_r + {{(`PC_W-`OFFSET_W-1){instr_r[10]}},
                           instr_r[10:0], 1'b0}; // RQ2
      flush_r <= is_jump || skip_now; // RQ8
    end else begin
      wr_en_r <= 1'b0;
      pc_load_r <= 1'b0;
      flush_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // second-cycle control
  // ----------------------------------------------------------------
  // a jump or a skip turns the next instruction cycle into a nop
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_r <= ST_EXEC;
    end else if (phase_r == `PH_Q4) begin
      unique case (state_r)
        ST_EXEC: begin
          if (flush_r) begin
            state_r <= ST_NOP; // RQ3 RQ8
          end
        end
        ST_NOP: begin
          state_r <= ST_EXEC; // RQ9
        end
      endcase
    end
  end

  // outputs
  assign mem_addr = mem_addr_r;
  assign mem_rd_en = rd_en_r;
  assign mem_wr_en = wr_en_r;
  assign mem_wdata = wdata_r;
  assign pc_load = pc_load_r;
  assign pc_next = pc_next_r;
  assign flush = flush_r;
  assign phase = phase_r;
  assign nop_cycle = state_r == ST_NOP;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_quiet4;
    (!mem_rd_en && !mem_wr_en && !pc_load)[*4];
  endsequence

  property p_jump_decode;
    pc_load |-> $past(is_jump) && instr_r[15:11] == 5'h1a;
  endproperty
  a_jump_decode: assert property (p_jump_decode) // RQ1
    else $error("pc load without a jump word");

  property p_jump_target;
    pc_load |-> pc_next == pc_r + {{9{instr_r[10]}}, instr_r[10:0], 1'b0};
  endproperty
  a_jump_target: assert property (p_jump_target) // RQ2
    else $error("jump target wrong");

  property p_jump_two_cycles;
    pc_load |-> phase == 2'h3 ##1 s_quiet4;
  endproperty
  a_jump_two_cycles: assert property (p_jump_two_cycles) // RQ3
    else $error("jump not in q4 or second cycle busy");

  property p_set_rmw;
    mem_wr_en |-> (mem_wdata == (rdata_r | bit_mask)) &&
                  mem_wdata[instr_r[11:9]] && $past(mem_rd_en, 2);
  endproperty
  a_set_rmw: assert property (p_set_rmw) // RQ4
    else $error("bit set write wrong");

  property p_bank_sel;
    mem_rd_en && instr_r[8] |-> mem_addr[11:8] == $past(bank_select_register);
  endproperty
  a_bank_sel: assert property (p_bank_sel) // RQ5
    else $error("bank select not applied");

  property p_indexed;
    mem_rd_en && !instr_r[8] && $past(ext_set_en) && instr_r[7:0] <= 8'h5f
      |-> mem_addr == $past(index_base) + {4'h0, instr_r[7:0]};
  endproperty
  a_indexed: assert property (p_indexed) // RQ6
    else $error("indexed address wrong");

  property p_skip_one;
    phase == 2'h2 && is_sko && bit_val |=> flush ##1 nop_cycle;
  endproperty
  a_skip_one: assert property (p_skip_one) // RQ7
    else $error("skip on one missed");

  property p_skip_nop;
    flush |=> s_quiet4 ##0 nop_cycle;
  endproperty
  a_skip_nop: assert property (p_skip_nop) // RQ8
    else $error("discarded word not replaced by nop");

  property p_no_skip;
    phase == 2'h2 && (is_skz || is_sko) && !skip_now |=> !flush ##1 !nop_cycle;
  endproperty
  a_no_skip: assert property (p_no_skip) // RQ9
    else $error("test took two cycles without skip");
endmodule : branch_bitset_decode
`default_nettype wire

// [tb.sv]
/*
 self-checking bench for branch_bitset_decode: relative_jump targets,
 file_bit_set addressing, both test-and-skip forms and nop cycles.
 assumes the decoder's own assertions sit inside the design files,
 and that one instruction cycle spans four sys_clk edges.
*/
`default_nettype none
module tb
  import branch_bitset_decode_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic sys_clk, rst_n, instr_valid, ext_set_en;
  logic [15:0] instr_word; // fetched word
  prog_addr_t pc_inc, pc_next;
  logic [3:0] bank_bits; // bank select bits driven into the core
  logic [11:0] index_base;
  data_addr_t mem_addr;
  logic mem_rd_en, mem_wr_en, pc_load, flush, nop_cycle;
  logic [7:0] mem_rdata, mem_wdata;
  logic [1:0] phase;
  // outputs captured once per instruction cycle
  logic s_rd, s_wr, s_ld, s_fl, s_nop;
  logic [1:0] s_ph; // phase seen together with the results
  data_addr_t s_addr;
  logic [7:0] s_wd;
  prog_addr_t s_pc;
  int n_fail, cmp_count;

  branch_bitset_decode dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .instr_word(instr_word),
    .instr_valid(instr_valid), .pc_inc(pc_inc),
    .bank_select_register(bank_bits), .ext_set_en(ext_set_en),
    .index_base(index_base), .mem_addr(mem_addr),
    .mem_rd_en(mem_rd_en), .mem_rdata(mem_rdata),
    .mem_wr_en(mem_wr_en), .mem_wdata(mem_wdata), .pc_load(pc_load),
    .pc_next(pc_next), .flush(flush), .phase(phase),
    .nop_cycle(nop_cycle));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic stop_test();
    if (n_fail == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test

  task automatic chk_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask : chk_bit

  task automatic chk_val(input logic [20:0] got, input logic [20:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask : chk_val

  // present one word in Q1 and capture the Q2 read, the Q4 results and the next cycle's nop flag;
  // inputs move on falling edges so the sampling edge never races
  task automatic exec(input logic [15:0] w, input prog_addr_t pc,
                      input logic [7:0] rd);
    int i;
    i = 0;
    while (phase !== 2'h0 && i < 8) begin
      @(negedge sys_clk);
      i++;
    end
    instr_word = w;
    pc_inc = pc;
    mem_rdata = rd;
    instr_valid = 1'b1;
    @(negedge sys_clk);
    s_rd = mem_rd_en;
    s_addr = mem_addr;
    instr_valid = 1'b0;
    repeat (2) @(negedge sys_clk);
    s_wr = mem_wr_en;
    s_wd = mem_wdata;
    s_ld = pc_load;
    s_pc = pc_next;
    s_ph = phase;
    s_fl = flush;
    @(negedge sys_clk);
    s_nop = nop_cycle;
  endtask : exec

  // judge one bit-oriented cycle; address only matters when read
  task automatic expect_cyc(input logic rd, input logic [11:0] ad,
      input logic wr, input logic [7:0] wd, input logic sk);
    chk_bit(s_rd, rd);
    if (rd) chk_val(21'(s_addr), 21'(ad));
    chk_bit(s_wr, wr);
    if (wr) chk_val(21'(s_wd), 21'(wd));
    chk_bit(s_ld, 1'b0);
    chk_bit(s_fl, sk);
    chk_bit(s_nop, sk);
  endtask : expect_cyc

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_set_banked();
    bank_bits = 4'h3;
    ext_set_en = 1'b0;
    exec(16'h8f25, 21'h0, 8'h0a);
    expect_cyc(1'b1, 12'h325, 1'b1, 8'h8a, 1'b0);
    exec(16'h8100, 21'h0, 8'h80);
    expect_cyc(1'b1, 12'h300, 1'b1, 8'h81, 1'b0);
  endtask : t_set_banked

  task automatic t_set_access();
    // both sides of the access split, bank bits must be ignored
    exec(16'h8e5f, 21'h0, 8'h00);
    expect_cyc(1'b1, 12'h05f, 1'b1, 8'h80, 1'b0);
    exec(16'h8260, 21'h0, 8'h00);
    expect_cyc(1'b1, 12'hf60, 1'b1, 8'h02, 1'b0);
  endtask : t_set_access

  task automatic t_set_indexed();
    ext_set_en = 1'b1;
    index_base = 12'hff0; // base chosen so the sum wraps
    exec(16'h8e5f, 21'h0, 8'h01);
    expect_cyc(1'b1, 12'h04f, 1'b1, 8'h81, 1'b0);
    exec(16'h8260, 21'h0, 8'h00);
    expect_cyc(1'b1, 12'hf60, 1'b1, 8'h02, 1'b0);
    bank_bits = 4'h2;
    exec(16'h8310, 21'h0, 8'h00);
    expect_cyc(1'b1, 12'h210, 1'b1, 8'h02, 1'b0);
    ext_set_en = 1'b0;
  endtask : t_set_indexed

  task automatic t_jump();
    logic [15:0] w[4] = '{16'hd7ff, 16'hd3ff, 16'hd400, 16'hd7ff};
    prog_addr_t pc[4] = '{21'h100, 21'h100, 21'h1000, 21'h0};
    prog_addr_t ex[4] = '{21'hfe, 21'h8fe, 21'h800, 21'h1ffffe};
    // top five bits 11011 are not a jump: nothing may move
    exec(16'hd800, 21'h100, 8'h00);
    expect_cyc(1'b0, 12'h0, 1'b0, 8'h0, 1'b0);
    for (int k = 0; k < 4; k++) begin
      exec(w[k], pc[k], 8'h00);
      chk_val(s_pc, ex[k]);
      chk_bit(s_ld, 1'b1);
      chk_bit(s_wr, 1'b0);
      chk_bit(s_nop, 1'b1);
      chk_val(21'(s_ph), 21'h3);
      // a word offered in the nop cycle must do nothing
      exec(16'h8f25, 21'h0, 8'h00);
      expect_cyc(1'b0, 12'h0, 1'b0, 8'h0, 1'b0);
    end
  endtask : t_jump

  task automatic t_skip();
    logic [3:0] op;
    logic [7:0] rd;
    logic sk;
    for (int k = 0; k < 4; k++) begin
      op = k[1] ? 4'hb : 4'ha;
      rd = k[0] ? 8'h08 : 8'hf7;
      sk = (op == 4'ha) ? rd[3] : !rd[3];
      exec({op, 12'h625}, 21'h0, rd);
      expect_cyc(1'b1, 12'h025, 1'b0, 8'h0, sk);
      if (sk) begin
        exec(16'h8f25, 21'h0, 8'h00);
        expect_cyc(1'b0, 12'h0, 1'b0, 8'h0, 1'b0);
      end
    end
  endtask : t_skip

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    n_fail = 0;
    cmp_count = 0;
    rst_n = 1'b0;
    instr_word = 16'h0;
    instr_valid = 1'b0;
    pc_inc = 21'h0;
    bank_bits = 4'h0;
    ext_set_en = 1'b0;
    index_base = 12'h0;
    mem_rdata = 8'h0;
    repeat (20) @(negedge sys_clk);
    rst_n = 1'b1;
    t_set_banked();
    t_set_access();
    t_set_indexed();
    t_jump();
    t_skip();
    stop_test();
  end

  // about 30 instruction cycles are needed; allow far more
  initial begin
    repeat (3000) @(posedge sys_clk);
    n_fail++;
    stop_test();
  end
endmodule : tb
`default_nettype wire
